// >>> src/lsca_alu_dev.sv
// Functional notes
// [RL1] AND, XOR or OR of both sources
// [RL2] Bit clear And_set_flags first with inverted second
// [RL3] Logical ops set N,Z; keep C,V
// [RL4] Logical operands only low eight, dst=first
// [RL5] Shift immediates 1-32 right, 0-31 left
// [RL6] Register shift amount uses low byte only
// [RL7] Arith right, left, right, rotate right shifts
// [RL8] Shifts low registers; register form dst=value
// [RL9] Shifts set N,Z, C=last out, keep V
// [RL10] Flag copy equals left shift by zero
// [RL11] Compare subtracts, sets flags, no write
// [RL12] Compare-add adds, sets flags, discards sum
// [RL13] Compares update all four flags
// [RL14] Compare regs R0-R14, imm 0-255, add low
// [RL15] Add carry chains into add-with-carry
// [RL16] Subtract borrow chains through subtract-with-carry
// [RL17] Reverse subtract from zero negates source
// [RL18] Logical first operand register is destination
// [RL19] Missing shift destination is value register
// [RL20] Add-with-carry adds carry, writes, sets NZCV
// [RL21] 32-bit results, N=bit31, Z=all zero
`timescale 1ns/1ps
module lsca_alu_dev
    import lsca_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    lsca_if.dev bus,
    output lsca_flags_t flagsOut
);

    // Whole registered state of the datapath
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] result;
        lsca_flags_t flags;
    } lsca_dev_state_t;

    localparam lsca_dev_state_t LSCA_DEV_RST = '{
        valid: 1'b0,
        write: 1'b0,
        result: 32'h00000000,
        flags: LSCA_FLAGS_RST
    };

    lsca_dev_state_t state_reg;
    lsca_dev_state_t state_next;

    // Adder core: sum with carry in, carry and signed overflow out
    function automatic lsca_arith_t add_core(
        logic [31:0] a,
        logic [31:0] b,
        logic cin
    );
        lsca_arith_t r;
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b} + {32'h00000000, cin};
        r.res = s[31:0];
        r.c = s[32];
        r.v = (a[31] == b[31]) && (s[31] != a[31]);
        return r;
    endfunction : add_core

    // Barrel shifter with carry out of the last bit leaving
    function automatic lsca_arith_t shift_core(
        lsca_op_t op,
        logic [31:0] a,
        logic [7:0] amt,
        logic cin
    );
        lsca_arith_t r;
        logic [5:0] n;
        logic [32:0] w;
        logic signed [32:0] sw;
        // Amounts above a word behave as one past the word
        n = (amt > LSCA_AMT_WORD) ? LSCA_AMT_OVER : amt[5:0];
        w = 33'h000000000;
        sw = 33'h000000000;
        r.res = a;
        r.c = cin;
        r.v = 1'b0;
        // Zero length keeps the value and the carry
        if (amt != 8'h00) begin // [RL9]
            unique case (op)
                OP_LOGICAL_LEFT_SHIFT: begin // [RL7]
                    w = {1'b0, a} << n;
                    r.res = w[31:0];
                    r.c = w[32];
                end
                OP_LOGICAL_RIGHT_SHIFT: begin // [RL7]
                    w = {a, 1'b0} >> n;
                    r.res = w[32:1];
                    r.c = w[0];
                end
                OP_ARITH_RIGHT_SHIFT: begin // [RL7]
                    sw = $signed({a, 1'b0}) >>> n;
                    r.res = sw[32:1];
                    r.c = sw[0];
                end
                OP_ROTATE_RIGHT: begin // [RL7]
                    r.res = (a >> amt[4:0])
                        | (a << (LSCA_ROT_BASE - {1'b0, amt[4:0]}));
                    r.c = r.res[31];
                end
                default: begin
                    r.res = a;
                    r.c = cin;
                end
            endcase
        end
        return r;
    endfunction : shift_core

    // Next state: compute one operation per accepted request
    always_comb begin
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] res;
        logic cOut;
        logic vOut;
        lsca_arith_t ar;
        a = bus.opA;
        b = bus.opB;
        res = 32'h00000000;
        cOut = state_reg.flags.c;
        vOut = state_reg.flags.v;
        ar = '0;
        state_next = state_reg;
        state_next.valid = 1'b0;
        if (bus.opValid) begin
            state_next.valid = 1'b1;
            state_next.write = 1'b1;
            unique case (bus.opCode)
                // Logical group leaves carry and overflow alone
                OP_AND_SET_FLAGS: begin
                    res = a & b; // [RL1] [RL3]
                end
                OP_OR_SET_FLAGS: begin
                    res = a | b; // [RL1] [RL3]
                end
                OP_XOR_SET_FLAGS: begin
                    res = a ^ b; // [RL1] [RL3]
                end
                OP_BIT_CLEAR_SET_FLAGS: begin
                    res = a & ~b; // [RL2] [RL3]
                end
                // Amount from the low byte of the second operand
                OP_ARITH_RIGHT_SHIFT,
                OP_LOGICAL_LEFT_SHIFT,
                OP_LOGICAL_RIGHT_SHIFT,
                OP_ROTATE_RIGHT: begin
                    ar = shift_core(bus.opCode, a, b[7:0],
                        state_reg.flags.c); // [RL5] [RL6] [RL9]
                    res = ar.res;
                    cOut = ar.c;
                end
                // Copy is a left shift by zero
                OP_COPY_SET_FLAGS: begin
                    ar = shift_core(OP_LOGICAL_LEFT_SHIFT, a, 8'h00,
                        state_reg.flags.c); // [RL10]
                    res = ar.res;
                    cOut = ar.c;
                end
                // Compares: flags only, no write back
                OP_COMPARE_SUBTRACT: begin
                    ar = add_core(a, ~b, 1'b1); // [RL11] [RL13]
                    state_next.write = 1'b0;
                    res = ar.res;
                    cOut = ar.c;
                    vOut = ar.v;
                end
                OP_COMPARE_ADD: begin
                    ar = add_core(a, b, 1'b0); // [RL12] [RL13]
                    state_next.write = 1'b0;
                    res = ar.res;
                    cOut = ar.c;
                    vOut = ar.v;
                end
                // Carry flag is the chaining link between words
                OP_ADD_WITH_CARRY: begin
                    ar = add_core(a, b, state_reg.flags.c); // [RL15] [RL20]
                    res = ar.res;
                    cOut = ar.c;
                    vOut = ar.v;
                end
                OP_SUBTRACT_WITH_CARRY: begin
                    // Clear carry means a borrow is pending
                    ar = add_core(a, ~b, state_reg.flags.c); // [RL16]
                    res = ar.res;
                    cOut = ar.c;
                    vOut = ar.v;
                end
                OP_REVERSE_SUBTRACT: begin
                    ar = add_core(b, ~a, 1'b1); // [RL17]
                    res = ar.res;
                    cOut = ar.c;
                    vOut = ar.v;
                end
                OP_SUBTRACT_SET_FLAGS: begin
                    ar = add_core(a, ~b, 1'b1); // [RL16]
                    res = ar.res;
                    cOut = ar.c;
                    vOut = ar.v;
                end
                OP_ADD_SET_FLAGS: begin
                    ar = add_core(a, b, 1'b0); // [RL15]
                    res = ar.res;
                    cOut = ar.c;
                    vOut = ar.v;
                end
            endcase
            state_next.result = res;
            state_next.flags.n = res[31]; // [RL21]
            state_next.flags.z = (res == 32'h00000000); // [RL21]
            state_next.flags.c = cOut;
            state_next.flags.v = vOut;
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= LSCA_DEV_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Answer towards decode
    assign bus.resValid = state_reg.valid;
    assign bus.resWrite = state_reg.write;
    assign bus.result = state_reg.result;
    assign bus.flags = state_reg.flags;
    assign flagsOut = state_reg.flags;

endmodule : lsca_alu_dev

// >>> inc/lsca_pkg.sv
package lsca_pkg;
    // Datapath geometry
    localparam int LSCA_W = 32;
    localparam int LSCA_NREG = 16;
    localparam int LSCA_IDXW = 4;
    localparam int LSCA_AMTW = 8;
    // Register index limits
    localparam logic [3:0] LSCA_LOW_LIMIT = 4'h8;
    localparam logic [3:0] LSCA_CMP_LIMIT = 4'hF;
    // Immediate limits
    localparam logic [31:0] LSCA_IMM8_MAX = 32'h000000FF;
    localparam logic [31:0] LSCA_SHR_MIN = 32'h00000001;
    localparam logic [31:0] LSCA_SHR_MAX = 32'h00000020;
    localparam logic [31:0] LSCA_LSL_MAX = 32'h0000001F;
    // Shift amount clipping
    localparam logic [7:0] LSCA_AMT_WORD = 8'h20;
    localparam logic [5:0] LSCA_AMT_OVER = 6'h21;
    localparam logic [5:0] LSCA_ROT_BASE = 6'h20;

    // Operation codes
    typedef enum logic [3:0] {
        OP_AND_SET_FLAGS = 4'h0,
        OP_OR_SET_FLAGS = 4'h1,
        OP_XOR_SET_FLAGS = 4'h2,
        OP_BIT_CLEAR_SET_FLAGS = 4'h3,
        OP_ARITH_RIGHT_SHIFT = 4'h4,
        OP_LOGICAL_LEFT_SHIFT = 4'h5,
        OP_LOGICAL_RIGHT_SHIFT = 4'h6,
        OP_ROTATE_RIGHT = 4'h7,
        OP_COMPARE_SUBTRACT = 4'h8,
        OP_COMPARE_ADD = 4'h9,
        OP_ADD_WITH_CARRY = 4'hA,
        OP_SUBTRACT_WITH_CARRY = 4'hB,
        OP_REVERSE_SUBTRACT = 4'hC,
        OP_SUBTRACT_SET_FLAGS = 4'hD,
        OP_ADD_SET_FLAGS = 4'hE,
        OP_COPY_SET_FLAGS = 4'hF
    } lsca_op_t;

    // Condition flags
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } lsca_flags_t;

    localparam lsca_flags_t LSCA_FLAGS_RST = 4'h0;

    // Result word with carry and overflow
    typedef struct packed {
        logic [31:0] res;
        logic c;
        logic v;
    } lsca_arith_t;

    // Register lies among the low eight
    function automatic logic lsca_is_low(logic [3:0] idx);
        return idx < LSCA_LOW_LIMIT;
    endfunction : lsca_is_low
endpackage : lsca_pkg

// >>> inc/lsca_if.sv
`timescale 1ns/1ps
interface lsca_if;
    import lsca_pkg::*;
    logic opValid;
    lsca_op_t opCode;
    logic [31:0] opA;
    logic [31:0] opB;
    logic resValid;
    logic resWrite;
    logic [31:0] result;
    lsca_flags_t flags;

    modport dev(
        input opValid,
        input opCode,
        input opA,
        input opB,
        output resValid,
        output resWrite,
        output result,
        output flags
    );

    modport host(
        output opValid,
        output opCode,
        output opA,
        output opB,
        input resValid,
        input resWrite,
        input result,
        input flags
    );
endinterface : lsca_if

// >>> src/lsca_decode_host.sv
`timescale 1ns/1ps
module lsca_decode_host
    import lsca_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    lsca_if.host bus,
    input wire logic cmdValid,
    output logic cmdReady,
    input lsca_op_t cmdOp,
    input wire logic cmdDstGiven,
    input wire logic [3:0] cmdDst,
    input wire logic [3:0] cmdSrc1,
    input wire logic [3:0] cmdSrc2,
    input wire logic cmdUseImm,
    input wire logic [31:0] cmdImm,
    output logic cmdDone,
    output logic cmdError,
    output lsca_flags_t flags,
    input wire logic loadValid,
    input wire logic [3:0] loadIdx,
    input wire logic [31:0] loadData,
    input wire logic [3:0] peekIdx,
    output logic [31:0] peekData
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT = 3'b100
    } lsca_hst_t;

    // Whole registered state of the decode side
    typedef struct packed {
        lsca_hst_t fsm;
        logic [15:0][31:0] regs;
        logic [3:0] dst;
        logic opValid;
        lsca_op_t opCode;
        logic [31:0] opA;
        logic [31:0] opB;
        logic done;
        logic error;
    } lsca_host_state_t;

    lsca_host_state_t state_reg;
    lsca_host_state_t state_next;

    // Operand legality per operation
    function automatic logic cmd_legal(
        lsca_op_t op,
        logic [3:0] d,
        logic [3:0] s1,
        logic [3:0] s2,
        logic imm,
        logic [31:0] v
    );
        logic low;
        logic ok;
        low = lsca_is_low(d) && lsca_is_low(s1) && (imm || lsca_is_low(s2));
        ok = 1'b0;
        unique case (op)
            OP_AND_SET_FLAGS, OP_OR_SET_FLAGS, OP_XOR_SET_FLAGS,
            OP_BIT_CLEAR_SET_FLAGS, OP_ADD_WITH_CARRY,
            OP_SUBTRACT_WITH_CARRY, OP_ROTATE_RIGHT: begin
                ok = low && !imm && (d == s1); // [RL4] [RL18] [RL8]
            end
            OP_LOGICAL_LEFT_SHIFT: begin
                ok = low && (imm ? (v <= LSCA_LSL_MAX) : (d == s1)); // [RL8]
            end
            OP_ARITH_RIGHT_SHIFT, OP_LOGICAL_RIGHT_SHIFT: begin
                ok = low && (imm ? (v >= LSCA_SHR_MIN && v <= LSCA_SHR_MAX)
                    : (d == s1)); // [RL5] [RL8]
            end
            OP_COPY_SET_FLAGS: begin
                ok = lsca_is_low(d) && lsca_is_low(s1);
            end
            OP_COMPARE_SUBTRACT: begin
                ok = (s1 < LSCA_CMP_LIMIT) && (imm ? (v <= LSCA_IMM8_MAX)
                    : (s2 < LSCA_CMP_LIMIT)); // [RL14]
            end
            OP_COMPARE_ADD: begin
                ok = lsca_is_low(s1) && lsca_is_low(s2) && !imm; // [RL14]
            end
            OP_REVERSE_SUBTRACT: begin
                ok = lsca_is_low(d) && lsca_is_low(s1) && imm
                    && (v == 32'h00000000); // [RL17]
            end
            OP_SUBTRACT_SET_FLAGS, OP_ADD_SET_FLAGS: begin
                ok = low && (!imm || (v <= LSCA_IMM8_MAX));
            end
        endcase
        return ok;
    endfunction : cmd_legal

    // Next state: accept, issue, then write back
    always_comb begin
        logic [3:0] dstSel;
        dstSel = cmdDstGiven ? cmdDst : cmdSrc1; // [RL19]
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.error = 1'b0;
        state_next.opValid = 1'b0;
        unique case (state_reg.fsm)
            ST_IDLE: begin
                if (cmdValid) begin
                    if (cmd_legal(cmdOp, dstSel, cmdSrc1, cmdSrc2,
                        cmdUseImm, cmdImm)) begin
                        state_next.fsm = ST_ISSUE;
                        state_next.opValid = 1'b1;
                        state_next.opCode = cmdOp;
                        state_next.dst = dstSel;
                        state_next.opA = state_reg.regs[cmdSrc1];
                        state_next.opB = cmdUseImm ? cmdImm
                            : state_reg.regs[cmdSrc2];
                    end else begin
                        state_next.error = 1'b1;
                    end
                end else if (loadValid) begin
                    state_next.regs[loadIdx] = loadData;
                end
            end
            ST_ISSUE: begin
                state_next.fsm = ST_WAIT;
            end
            ST_WAIT: begin
                if (bus.resValid) begin
                    if (bus.resWrite) begin
                        state_next.regs[state_reg.dst] = bus.result;
                    end
                    state_next.done = 1'b1;
                    state_next.fsm = ST_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.fsm <= ST_IDLE;
            state_reg.opCode <= OP_AND_SET_FLAGS;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request towards the datapath and user answers
    assign bus.opValid = state_reg.opValid;
    assign bus.opCode = state_reg.opCode;
    assign bus.opA = state_reg.opA;
    assign bus.opB = state_reg.opB;
    assign cmdReady = (state_reg.fsm == ST_IDLE);
    assign cmdDone = state_reg.done;
    assign cmdError = state_reg.error;
    assign flags = bus.flags;
    assign peekData = state_reg.regs[peekIdx];

endmodule : lsca_decode_host

// >>> dv/lsca_alu_props.sv
`timescale 1ns/1ps
module lsca_alu_props
    import lsca_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic opValid,
    input lsca_op_t opCode,
    input wire logic [31:0] opA,
    input wire logic [31:0] opB,
    input wire logic resValid,
    input wire logic resWrite,
    input wire logic [31:0] result,
    input lsca_flags_t flags
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Reference sums for the compare checks
    wire logic [32:0] subSum = {1'b0, opA} + {1'b0, ~opB} + 33'h1;
    wire logic [32:0] addSum = {1'b0, opA} + {1'b0, opB};

    a_answer_next: assert property (opValid |=> resValid ##1 !resValid)
        else $error("answer not exactly one cycle after request");
    a_and_result: assert property (
        opValid && opCode == OP_AND_SET_FLAGS
        |=> result == ($past(opA) & $past(opB)))
        else $error("and result wrong");
    a_xor_result: assert property (
        opValid && opCode == OP_XOR_SET_FLAGS
        |=> result == ($past(opA) ^ $past(opB)))
        else $error("xor result wrong");
    a_bic_result: assert property (
        opValid && opCode == OP_BIT_CLEAR_SET_FLAGS
        |=> result == ($past(opA) & ~$past(opB)))
        else $error("bit clear result wrong");
    a_logic_keeps_cv: assert property (
        opValid && opCode <= OP_BIT_CLEAR_SET_FLAGS
        |=> resWrite && $stable(flags[1:0]))
        else $error("logical op changed carry or overflow");
    a_nz_from_result: assert property (
        resValid && resWrite
        |-> flags.n == result[31] && flags.z == (result == 32'h0))
        else $error("n or z not taken from result");
    a_cmp_flags: assert property (
        opValid && opCode == OP_COMPARE_SUBTRACT
        |=> !resWrite && flags.c == $past(subSum[32])
            && flags.z == ($past(opA) == $past(opB)))
        else $error("compare flags wrong or result written");
    a_cmn_flags: assert property (
        opValid && opCode == OP_COMPARE_ADD
        |=> !resWrite && flags.c == $past(addSum[32])
            && flags.n == $past(addSum[31]))
        else $error("compare-add flags wrong or result written");
    a_shift_zero_hold: assert property (
        opValid && opCode inside {[OP_ARITH_RIGHT_SHIFT:OP_ROTATE_RIGHT]}
        && opB[7:0] == 8'h00
        |=> result == $past(opA) && $stable(flags[1:0]))
        else $error("zero-length shift altered value or carry");
    a_shift_one_left: assert property (
        opValid && opCode == OP_LOGICAL_LEFT_SHIFT && opB[7:0] == 8'h01
        |=> result == {$past(opA[30:0]), 1'b0} && flags.c == $past(opA[31]))
        else $error("left shift by one wrong");
    a_copy_as_lsl: assert property (
        opValid && opCode == OP_COPY_SET_FLAGS
        |=> result == $past(opA) && $stable(flags[1:0]))
        else $error("flag copy differs from zero shift");
    a_adc_sum: assert property (
        opValid && opCode == OP_ADD_WITH_CARRY
        |=> result == $past(opA) + $past(opB) + {31'h0, $past(flags[1])})
        else $error("add with carry sum wrong");
    a_rsb_negate: assert property (
        opValid && opCode == OP_REVERSE_SUBTRACT
        |=> result == $past(opB) - $past(opA))
        else $error("reverse subtract wrong");
endmodule : lsca_alu_props

// >>> dv/logic_shift_compare_alu_tb.sv
`timescale 1ns/1ps
module logic_shift_compare_alu_tb;
    import lsca_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmdValid = 1'b0, cmdDstGiven = 1'b0, cmdUseImm = 1'b0;
    logic loadValid = 1'b0;
    lsca_op_t cmdOp = OP_AND_SET_FLAGS;
    logic [3:0] cmdDst = 4'h0, cmdSrc1 = 4'h0, cmdSrc2 = 4'h0;
    logic [3:0] loadIdx = 4'h0, peekIdx = 4'h0;
    logic [31:0] cmdImm = 32'h0, loadData = 32'h0, peekData;
    logic cmdReady, cmdDone, cmdError;
    lsca_flags_t flags, mf, devFlags;
    logic [31:0] model [16];
    int n_mismatch = 0, total_checks = 0;
    lsca_if lnk();

    // Free-running core clock
    always #5 clk = ~clk;

    lsca_alu_dev lsca_alu_dev_i(.clk(clk), .reset(reset), .bus(lnk.dev),
        .flagsOut(devFlags));
    lsca_decode_host lsca_decode_host_i(.clk(clk), .reset(reset),
        .bus(lnk.host), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdOp(cmdOp), .cmdDstGiven(cmdDstGiven), .cmdDst(cmdDst),
        .cmdSrc1(cmdSrc1), .cmdSrc2(cmdSrc2), .cmdUseImm(cmdUseImm),
        .cmdImm(cmdImm), .cmdDone(cmdDone), .cmdError(cmdError),
        .flags(flags), .loadValid(loadValid), .loadIdx(loadIdx),
        .loadData(loadData), .peekIdx(peekIdx), .peekData(peekData));
    lsca_alu_props lsca_alu_props_i(.clk(clk), .reset(reset),
        .opValid(lnk.opValid), .opCode(lnk.opCode), .opA(lnk.opA),
        .opB(lnk.opB), .resValid(lnk.resValid), .resWrite(lnk.resWrite),
        .result(lnk.result), .flags(lnk.flags));

    // Compare and count
    task automatic check(logic [35:0] seen, logic [35:0] exp, string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what,
                seen, exp);
        end
    endtask : check

    // Expected {result, n, z, c, v}
    function automatic logic [35:0] ref_alu(lsca_op_t op, logic [31:0] a,
        logic [31:0] b, lsca_flags_t f);
        logic [63:0] w;
        logic [31:0] r, x, y;
        logic [32:0] s;
        logic c, v, ar, ci;
        int k, m;
        k = b[7:0];
        m = b[4:0];
        {r, c, v, ar, x, y, ci} = {a, f.c, f.v, 1'b0, a, b, 1'b0};
        case (op)
            OP_AND_SET_FLAGS: r = a & b;
            OP_OR_SET_FLAGS: r = a | b;
            OP_XOR_SET_FLAGS: r = a ^ b;
            OP_BIT_CLEAR_SET_FLAGS: r = a & ~b;
            OP_LOGICAL_LEFT_SHIFT: if (k != 0) begin
                w = {32'h0, a} << k;
                {r, c} = {w[31:0], w[32]};
            end
            OP_LOGICAL_RIGHT_SHIFT: if (k != 0) begin
                w = {a, 32'h0} >> k;
                {r, c} = {w[63:32], w[31]};
            end
            OP_ARITH_RIGHT_SHIFT: if (k != 0) begin
                w = $signed({a, 32'h0}) >>> k;
                {r, c} = {w[63:32], w[31]};
            end
            OP_ROTATE_RIGHT: if (k != 0) begin
                r = (a >> m) | (a << (32 - m));
                c = r[31];
            end
            OP_COMPARE_SUBTRACT, OP_SUBTRACT_SET_FLAGS:
                {ar, y, ci} = {1'b1, ~b, 1'b1};
            OP_COMPARE_ADD, OP_ADD_SET_FLAGS: ar = 1'b1;
            OP_ADD_WITH_CARRY: {ar, ci} = {1'b1, f.c};
            OP_SUBTRACT_WITH_CARRY: {ar, y, ci} = {1'b1, ~b, f.c};
            OP_REVERSE_SUBTRACT: {ar, x, y, ci} = {1'b1, b, ~a, 1'b1};
            default: ;
        endcase
        if (ar) begin
            s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
            {r, c} = {s[31:0], s[32]};
            v = (x[31] == y[31]) && (r[31] != x[31]);
        end
        return {r, r[31], r == 32'h0, c, v};
    endfunction : ref_alu

    // Preload one register
    task automatic load(logic [3:0] i, logic [31:0] dat);
        @(negedge clk);
        {loadValid, loadIdx, loadData} = {1'b1, i, dat};
        model[i] = dat;
        @(negedge clk);
        loadValid = 1'b0;
    endtask : load

    // Issue one command and check refusal, register and flags
    task automatic run(lsca_op_t op, logic [3:0] d, logic [3:0] s1,
        logic [3:0] s2, logic gd, logic ui, logic [31:0] imm, logic expErr);
        logic [35:0] e;
        logic [3:0] dst;
        int t;
        e = ref_alu(op, model[s1], ui ? imm : model[s2], mf);
        dst = gd ? d : s1;
        @(negedge clk);
        {cmdOp, cmdDst, cmdSrc1, cmdSrc2, cmdDstGiven, cmdUseImm, cmdImm} =
            {op, d, s1, s2, gd, ui, imm};
        cmdValid = 1'b1;
        @(negedge clk);
        cmdValid = 1'b0;
        check({35'h0, cmdReady}, {35'h0, expErr}, "ready");
        t = 0;
        while (cmdDone !== 1'b1 && cmdError !== 1'b1 && t < 20) begin
            @(negedge clk);
            t++;
        end
        check({34'h0, cmdError, cmdDone}, {34'h0, expErr, !expErr},
            "refusal");
        if (!expErr) begin
            mf = e[3:0];
            if (!(op inside {OP_COMPARE_SUBTRACT, OP_COMPARE_ADD}))
                model[dst] = e[35:4];
        end
        peekIdx = dst;
        #1;
        check({peekData, flags}, {model[dst], mf}, "result");
        check({32'h0, devFlags}, {32'h0, mf}, "device flags");
    endtask : run

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        $display("mismatch at %0t: run timed out", $time);
        complete_run();
    end

    // Main sequence
    initial begin
        lsca_op_t op;
        logic [3:0] s1, s2;
        logic ui;
        logic [31:0] imm;
        static logic [7:0] amt [6] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h21,
            8'hFF};
        void'($urandom(41379));
        for (int i = 0; i < 16; i++) model[i] = 32'h0;
        mf = LSCA_FLAGS_RST;
        repeat (12) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        // Chained 64-bit add and 96-bit subtract
        load(4'h0, 32'hFFFFFFFF);
        load(4'h1, 32'h7FFFFFFF);
        load(4'h2, 32'h00000001);
        run(OP_ADD_SET_FLAGS, 4'h0, 4'h0, 4'h2, 0, 0, 0, 0);
        run(OP_ADD_WITH_CARRY, 4'h1, 4'h1, 4'h3, 0, 0, 0, 0);
        load(4'h4, 32'h0);
        run(OP_SUBTRACT_SET_FLAGS, 4'h4, 4'h4, 4'h2, 0, 0, 0, 0);
        run(OP_SUBTRACT_WITH_CARRY, 4'h5, 4'h5, 4'h3, 0, 0, 0, 0);
        run(OP_SUBTRACT_WITH_CARRY, 4'h6, 4'h6, 4'h3, 0, 0, 0, 0);
        load(4'h7, 32'h00000005);
        run(OP_REVERSE_SUBTRACT, 4'h7, 4'h7, 4'h0, 0, 1, 0, 0);
        run(OP_COPY_SET_FLAGS, 4'h3, 4'h5, 4'h0, 1, 0, 0, 0);
        load(4'hE, 32'h80000000);
        load(4'h9, 32'h80000000);
        run(OP_COMPARE_SUBTRACT, 4'h0, 4'hE, 4'h9, 0, 0, 0, 0);
        run(OP_COMPARE_SUBTRACT, 4'h0, 4'hE, 4'h0, 0, 1, 255, 0);
        // Register shift amounts with junk in the upper bits
        for (int j = 0; j < 6; j++) begin
            for (int o = 4; o < 8; o++) begin
                load(4'h1, 32'hC3A50181);
                load(4'h2, {24'hABCDEF, amt[j]});
                run(lsca_op_t'(o), 4'h1, 4'h1, 4'h2, 0, 0, 0, 0);
            end
        end
        // Immediate shift limits
        run(OP_LOGICAL_LEFT_SHIFT, 0, 4'h1, 0, 0, 1, 31, 0);
        run(OP_LOGICAL_RIGHT_SHIFT, 0, 4'h1, 0, 0, 1, 32, 0);
        run(OP_ARITH_RIGHT_SHIFT, 0, 4'h7, 0, 0, 1, 32, 0);
        // Operand combinations the host refuses
        run(OP_AND_SET_FLAGS, 4'h2, 4'h1, 4'h0, 1, 0, 0, 1);
        run(OP_OR_SET_FLAGS, 4'h1, 4'h1, 4'h8, 0, 0, 0, 1);
        run(OP_LOGICAL_LEFT_SHIFT, 0, 4'h1, 0, 0, 1, 32, 1);
        run(OP_ARITH_RIGHT_SHIFT, 0, 4'h1, 0, 0, 1, 0, 1);
        run(OP_ROTATE_RIGHT, 0, 4'h1, 0, 0, 1, 3, 1);
        run(OP_LOGICAL_RIGHT_SHIFT, 4'h3, 4'h1, 4'h2, 1, 0, 0, 1);
        run(OP_COMPARE_SUBTRACT, 0, 4'h1, 0, 0, 1, 256, 1);
        run(OP_COMPARE_SUBTRACT, 0, 4'hF, 4'h1, 0, 0, 0, 1);
        run(OP_COMPARE_ADD, 0, 4'h1, 4'h8, 0, 0, 0, 1);
        // Random legal traffic
        for (int i = 0; i < 200; i++) begin
            op = lsca_op_t'($urandom_range(15, 0));
            s1 = 4'($urandom_range(7, 0));
            s2 = 4'($urandom_range(7, 0));
            ui = 1'($urandom_range(1, 0));
            load(s1, $urandom);
            load(s2, $urandom);
            case (op)
                OP_LOGICAL_LEFT_SHIFT: imm = $urandom_range(31, 0);
                OP_ARITH_RIGHT_SHIFT, OP_LOGICAL_RIGHT_SHIFT:
                    imm = $urandom_range(32, 1);
                OP_COMPARE_SUBTRACT, OP_ADD_SET_FLAGS, OP_SUBTRACT_SET_FLAGS:
                    imm = $urandom_range(255, 0);
                OP_REVERSE_SUBTRACT: {ui, imm} = {1'b1, 32'h0};
                default: {ui, imm} = {1'b0, 32'h0};
            endcase
            run(op, s1, s1, s2, 0, ui, imm, 0);
        end
        complete_run();
    end
endmodule : logic_shift_compare_alu_tb
